// ==== fwsr_pkg.sv ====
// shared constants, types and register map of the flash status host controller
package fwsr_pkg;
    // clock and flash bus timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WE_LOW_NS = 40;
    localparam int T_WE_REC_NS = 20;
    localparam int T_READ_NS = 100;
    localparam int T_ERASE_GAP_US = 50;
    localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_REC_CYC = (T_WE_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_GAP_CYC = (T_ERASE_GAP_US * 1000) / CLK_PERIOD_NS;

    // status word bit positions
    localparam int SB_POLL = 7;
    localparam int SB_TOGGLE = 6;
    localparam int SB_TLIMIT = 5;
    localparam int SB_ETIMER = 3;
    localparam int SB_ABORT = 1;

    // software register indices
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_ADDR = 3'h1;
    localparam logic [2:0] REG_WDATA = 3'h2;
    localparam logic [2:0] REG_RDATA = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;
    localparam logic [2:0] REG_MASK = 3'h5;

    // control register fields
    localparam int CTL_GO = 3;
    localparam int CTL_USE_LAST = 4;
    localparam int CTL_FAST = 5;

    // operations
    localparam logic [2:0] OP_WRITE = 3'h0;
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_ERASE_ADD = 3'h2;
    localparam logic [2:0] OP_POLL = 3'h3;
    localparam logic [2:0] OP_ABORT_RST = 3'h4;

    // status events
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_ABORT = 2;
    localparam int EV_REJECT = 3;
    localparam int EV_REFUSED = 4;
    localparam int EV_W = 5;
    localparam logic [EV_W-1:0] EV_RESET = 5'h00;

    typedef enum {S_IDLE, S_DECIDE, S_WR_PULSE, S_WR_REC, S_RD_WAIT} fwsr_state_t;
    typedef enum {K_FIN, K_WR, K_RD} fwsr_kind_t;

    // flash control strobes, all active low
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
    } fwsr_ctl_t;
    localparam fwsr_ctl_t CTL_IDLE = 4'hf;
endpackage

// ==== fwsr_host.sv ====
// host controller driving a parallel nor flash and decoding its status word
`timescale 1ns/1ns

module fwsr_host #(
    parameter int AW = 22,
    parameter int DW = 16,
    parameter int GAP_CYC = fwsr_pkg::ERASE_GAP_CYC,
    parameter logic [3*AW-1:0] ABORT_SEQ_ADDR = '0,
    parameter logic [3*DW-1:0] ABORT_SEQ_DATA = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // software register port
    input wire logic [2:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic irq,
    // flash pins
    output logic [AW-1:0] flash_addr,
    output logic [DW-1:0] flash_dq_out,
    input wire logic [DW-1:0] flash_dq_in,
    output fwsr_pkg::fwsr_ctl_t flash_ctl,
    input wire logic flash_ready_busy_n
);
    localparam int EV_W_L = fwsr_pkg::EV_W;
    logic rst_meta_n;
    logic rst_n;
    fwsr_pkg::fwsr_state_t state;
    logic [7:0] cnt;
    logic [2:0] step;
    logic [2:0] op;
    logic use_last;
    logic fast;
    logic tlim_seen;
    logic needs_reset;
    logic [AW-1:0] reg_addr;
    logic [AW-1:0] last_wr_addr;
    logic [DW-1:0] reg_wdata;
    logic [DW-1:0] rd_data;
    logic [DW-1:0] prev_data;
    logic [EV_W_L-1:0] status;
    logic [EV_W_L-1:0] mask;
    logic [15:0] gap_cnt;

    fwsr_pkg::fwsr_kind_t next_kind;
    logic [AW-1:0] next_addr;
    logic [DW-1:0] next_data;
    logic [2:0] next_step;
    logic [EV_W_L-1:0] next_ev;
    logic [EV_W_L-1:0] start_ev;
    logic start;
    logic check;
    logic [AW-1:0] cur_addr;
    logic toggling;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // go request decode; busy or blocked requests raise a flag and still load the fast bit
    always_comb
    begin
        start = 1'b0;
        start_ev = fwsr_pkg::EV_RESET;
        if (sw_wr && sw_addr == fwsr_pkg::REG_CTRL && sw_wdata[fwsr_pkg::CTL_GO])
        begin
            if (state != fwsr_pkg::S_IDLE || (needs_reset && sw_wdata[2:0] != fwsr_pkg::OP_ABORT_RST))
                start_ev[fwsr_pkg::EV_REFUSED] = 1'b1;
            else
                start = 1'b1;
        end
    end

    // checks may be skipped only while the 50 us spacing is guaranteed
    assign check = !fast || (gap_cnt >= 16'(GAP_CYC));
    assign cur_addr = (op == fwsr_pkg::OP_POLL && use_last) ? last_wr_addr : reg_addr;
    assign toggling = rd_data[fwsr_pkg::SB_TOGGLE] != prev_data[fwsr_pkg::SB_TOGGLE];

    // sequencer: choose the next bus cycle from op, step and last status word
    always_comb
    begin
        next_kind = fwsr_pkg::K_FIN;
        next_addr = cur_addr;
        next_data = reg_wdata;
        next_step = step + 3'h1;
        next_ev = fwsr_pkg::EV_RESET;
        case (op)
            fwsr_pkg::OP_WRITE, fwsr_pkg::OP_READ:
            begin
                if (step == 3'h0)
                    next_kind = (op == fwsr_pkg::OP_WRITE) ? fwsr_pkg::K_WR : fwsr_pkg::K_RD;
                else
                    next_ev[fwsr_pkg::EV_DONE] = 1'b1;
            end
            fwsr_pkg::OP_ERASE_ADD:
            begin
                case (step)
                    3'h0:
                    begin
                        next_kind = check ? fwsr_pkg::K_RD : fwsr_pkg::K_WR;
                        next_step = check ? 3'h1 : 3'h2;
                    end
                    3'h1:
                    begin
                        // erase already running: adding would be ignored
                        if (rd_data[fwsr_pkg::SB_ETIMER])
                            next_ev[fwsr_pkg::EV_REJECT] = 1'b1;
                        else
                            next_kind = fwsr_pkg::K_WR;
                    end
                    3'h2:
                    begin
                        if (check)
                            next_kind = fwsr_pkg::K_RD;
                        else
                            next_ev[fwsr_pkg::EV_DONE] = 1'b1;
                    end
                    3'h3:
                        next_kind = fwsr_pkg::K_RD;
                    default:
                    begin
                        // not toggling or timer already high: command may be lost
                        if (rd_data[fwsr_pkg::SB_ETIMER] || !toggling)
                            next_ev[fwsr_pkg::EV_REJECT] = 1'b1;
                        next_ev[fwsr_pkg::EV_DONE] = 1'b1;
                    end
                endcase
            end
            fwsr_pkg::OP_POLL:
            begin
                // two fresh reads before the toggle bit is judged; the word left by an earlier op is stale
                next_step = (step == 3'h0) ? 3'h1 : 3'h2;
                if (step != 3'h2)
                    next_kind = fwsr_pkg::K_RD;
                else if (!toggling)
                    next_ev[fwsr_pkg::EV_DONE] = 1'b1;
                else if (rd_data[fwsr_pkg::SB_ABORT])
                    next_ev[fwsr_pkg::EV_ABORT] = 1'b1;
                else if (tlim_seen)
                    next_ev[fwsr_pkg::EV_FAIL] = 1'b1; // still toggling after the limit flag
                else
                    next_kind = fwsr_pkg::K_RD;
            end
            fwsr_pkg::OP_ABORT_RST:
            begin
                if (step < 3'h3)
                begin
                    next_kind = fwsr_pkg::K_WR;
                    next_addr = ABORT_SEQ_ADDR[AW*step +: AW];
                    next_data = ABORT_SEQ_DATA[DW*step +: DW];
                end
                else
                    next_ev[fwsr_pkg::EV_DONE] = 1'b1;
            end
            default:
                next_ev[fwsr_pkg::EV_REFUSED] = 1'b1;
        endcase
    end

    // bus cycle engine and flash pins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= fwsr_pkg::S_IDLE;
            cnt <= 8'h00;
            step <= 3'h0;
            flash_addr <= '0;
            flash_dq_out <= '0;
            flash_ctl <= fwsr_pkg::CTL_IDLE;
            rd_data <= '0;
            prev_data <= '0;
            tlim_seen <= 1'b0;
        end
        else
        begin
            case (state)
                fwsr_pkg::S_IDLE:
                begin
                    if (start)
                    begin
                        state <= fwsr_pkg::S_DECIDE;
                        step <= 3'h0;
                        tlim_seen <= 1'b0;
                    end
                end
                fwsr_pkg::S_DECIDE:
                begin
                    step <= next_step;
                    flash_addr <= next_addr;
                    flash_dq_out <= next_data;
                    case (next_kind)
                        fwsr_pkg::K_WR:
                        begin
                            flash_ctl <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, dq_oe_n: 1'b0};
                            cnt <= 8'(fwsr_pkg::WE_LOW_CYC - 1);
                            state <= fwsr_pkg::S_WR_PULSE;
                        end
                        fwsr_pkg::K_RD:
                        begin
                            flash_ctl <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, dq_oe_n: 1'b1};
                            cnt <= 8'(fwsr_pkg::READ_CYC - 1);
                            state <= fwsr_pkg::S_RD_WAIT;
                        end
                        default:
                            state <= fwsr_pkg::S_IDLE;
                    endcase
                end
                fwsr_pkg::S_WR_PULSE:
                begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h00)
                    begin
                        flash_ctl.we_n <= 1'b1;
                        cnt <= 8'(fwsr_pkg::WE_REC_CYC - 1);
                        state <= fwsr_pkg::S_WR_REC;
                    end
                end
                fwsr_pkg::S_WR_REC:
                begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h00)
                    begin
                        flash_ctl <= fwsr_pkg::CTL_IDLE;
                        state <= fwsr_pkg::S_DECIDE;
                    end
                end
                fwsr_pkg::S_RD_WAIT:
                begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h00)
                    begin
                        // keep the previous word for toggle comparison
                        prev_data <= rd_data;
                        rd_data <= flash_dq_in;
                        tlim_seen <= rd_data[fwsr_pkg::SB_TLIMIT];
                        flash_ctl <= fwsr_pkg::CTL_IDLE;
                        state <= fwsr_pkg::S_DECIDE;
                    end
                end
                default:
                    state <= fwsr_pkg::S_IDLE;
            endcase
        end
    end

    // erase spacing timer, restarted by each sector erase write
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            gap_cnt <= 16'hffff;
        else if (state == fwsr_pkg::S_DECIDE && op == fwsr_pkg::OP_ERASE_ADD && next_kind == fwsr_pkg::K_WR)
            gap_cnt <= 16'h0000;
        else if (gap_cnt != 16'hffff)
            gap_cnt <= gap_cnt + 16'h0001;
    end

    // software registers and abort lock
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op <= fwsr_pkg::OP_WRITE;
            use_last <= 1'b0;
            fast <= 1'b0;
            reg_addr <= '0;
            reg_wdata <= '0;
            mask <= '0;
            last_wr_addr <= '0;
            needs_reset <= 1'b0;
        end
        else
        begin
            if (sw_wr && sw_addr == fwsr_pkg::REG_CTRL)
                fast <= sw_wdata[fwsr_pkg::CTL_FAST];
            if (start)
            begin
                op <= sw_wdata[2:0];
                use_last <= sw_wdata[fwsr_pkg::CTL_USE_LAST];
            end
            if (sw_wr && sw_addr == fwsr_pkg::REG_ADDR && state == fwsr_pkg::S_IDLE)
                reg_addr <= sw_wdata[AW-1:0];
            if (sw_wr && sw_addr == fwsr_pkg::REG_WDATA && state == fwsr_pkg::S_IDLE)
                reg_wdata <= sw_wdata[DW-1:0];
            if (sw_wr && sw_addr == fwsr_pkg::REG_MASK)
                mask <= sw_wdata[EV_W_L-1:0];
            // last loaded location, the polling target for buffer programming
            if (state == fwsr_pkg::S_DECIDE && op == fwsr_pkg::OP_WRITE && next_kind == fwsr_pkg::K_WR)
                last_wr_addr <= next_addr;
            if (state == fwsr_pkg::S_DECIDE && next_ev[fwsr_pkg::EV_ABORT])
                needs_reset <= 1'b1;
            else if (state == fwsr_pkg::S_DECIDE && op == fwsr_pkg::OP_ABORT_RST && next_kind == fwsr_pkg::K_FIN)
                needs_reset <= 1'b0;
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            status <= fwsr_pkg::EV_RESET;
        else
            status <= (status & ~((sw_wr && sw_addr == fwsr_pkg::REG_STATUS) ? sw_wdata[EV_W_L-1:0] : '0))
                | start_ev | ((state == fwsr_pkg::S_DECIDE) ? next_ev : fwsr_pkg::EV_RESET);
    end

    // read port and interrupt
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_rdata <= 32'h0000_0000;
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status & mask);
            sw_rdata <= 32'h0000_0000;
            if (sw_rd)
            begin
                case (sw_addr)
                    fwsr_pkg::REG_CTRL: sw_rdata <= 32'({flash_ready_busy_n, needs_reset, state != fwsr_pkg::S_IDLE,
                        fast, use_last, 1'b0, op});
                    fwsr_pkg::REG_ADDR: sw_rdata <= 32'(reg_addr);
                    fwsr_pkg::REG_WDATA: sw_rdata <= 32'(reg_wdata);
                    fwsr_pkg::REG_RDATA: sw_rdata <= 32'(rd_data);
                    fwsr_pkg::REG_STATUS: sw_rdata <= 32'(status);
                    fwsr_pkg::REG_MASK: sw_rdata <= 32'(mask);
                    default: sw_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // checks on the status handling sequences
    sequence s_rd_start;
        state == fwsr_pkg::S_RD_WAIT && !flash_ctl.oe_n && flash_ctl.we_n;
    endsequence
    sequence s_erase_decide(int s);
        state == fwsr_pkg::S_DECIDE && op == fwsr_pkg::OP_ERASE_ADD && step == s;
    endsequence

    a_skip_when_fast: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_erase_decide(0) ##0 !check |=> !flash_ctl.we_n && state == fwsr_pkg::S_WR_PULSE)
        else $error("fast erase add did not write directly");
    a_pre_check_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_erase_decide(0) ##0 check |=> s_rd_start)
        else $error("erase add did not read timer before writing");
    a_toggle_before_timer: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_erase_decide(2) ##0 check |=> s_rd_start)
        else $error("no toggle read after erase write");
    a_reject_on_timer: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_erase_decide(4) ##0 rd_data[fwsr_pkg::SB_ETIMER] |=> status[fwsr_pkg::EV_REJECT])
        else $error("high timer after erase add not flagged");
    a_block_after_abort: assert property (@(posedge sys_clk) disable iff (!rst_n)
        needs_reset && op != fwsr_pkg::OP_ABORT_RST |-> flash_ctl.we_n)
        else $error("write issued before abort reset");
    a_refuse_while_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sw_wr && sw_addr == fwsr_pkg::REG_CTRL && sw_wdata[fwsr_pkg::CTL_GO] && needs_reset
        && sw_wdata[2:0] != fwsr_pkg::OP_ABORT_RST |=> status[fwsr_pkg::EV_REFUSED] && !$changed(op))
        else $error("blocked request was not refused");
    a_poll_valid_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_rd_start ##0 op == fwsr_pkg::OP_POLL && !use_last |-> flash_addr == reg_addr)
        else $error("status read at wrong address");
    a_poll_last_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_rd_start ##0 op == fwsr_pkg::OP_POLL && use_last |-> flash_addr == last_wr_addr)
        else $error("buffer poll not at last loaded address");
    a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 irq == $past(|(status & mask)))
        else $error("interrupt does not follow masked status");
endmodule

// ==== fwsr_flash_model.sv ====
// behavioural flash device answering the host controller's bus cycles
`timescale 1ns/1ns
module fwsr_flash_model (
    // clock
    input wire logic clk,
    // flash pins
    input wire logic [21:0] addr,
    input wire logic [15:0] dq_out,
    input wire fwsr_pkg::fwsr_ctl_t ctl,
    output logic [15:0] dq_in,
    output logic ready_busy_n,
    // scenario controls
    input wire logic [11:0] busy_len,
    input wire logic abort_on,
    input wire logic tlimit_on,
    // observation
    output logic [15:0] wr_cnt,
    output logic [15:0] rd_cnt,
    output logic [21:0] wr_addr,
    output logic [21:0] rd_addr
);
    localparam int WIN = 400;
    fwsr_pkg::fwsr_ctl_t prev = 4'hf;
    logic [15:0] mem = 16'h0000;
    logic [15:0] noise = 16'h5a5a;
    logic [11:0] tog_cnt = 12'h000;
    logic tog = 1'b0;
    logic tog2 = 1'b0;
    logic etimer = 1'b0;
    int win_cnt = 0;
    int wn = 0;
    int rn = 0;
    logic busy;
    logic erasing;
    logic [15:0] word;
    assign wr_cnt = 16'(wn);
    assign rd_cnt = 16'(rn);
    assign busy = (tog_cnt != 12'h000);
    assign erasing = (win_cnt != 0) || etimer;
    assign ready_busy_n = ~busy;
    // status word: poll bit low while erasing, else inverse of written bit
    assign word = {8'h00, erasing ? 1'b0 : ~mem[7], tog, tlimit_on, 1'b0, etimer, tog2, abort_on, 1'b0};
    // released bus shows a changing pattern, never the last value
    assign dq_in = (!ctl.ce_n && !ctl.oe_n) ? (busy ? word : mem) : noise;
    // write ends on we_n rise, read ends on oe_n rise
    always @(posedge clk)
    begin
        prev <= ctl;
        noise <= noise + 16'h3c71;
        if (win_cnt > 1)
            win_cnt <= win_cnt - 1;
        else if (win_cnt == 1)
        begin
            win_cnt <= 0;
            etimer <= 1'b1;
        end
        else if (!busy)
            etimer <= 1'b0;
        // a started erase ignores further commands
        if (!ctl.ce_n && ctl.we_n && !prev.we_n && !(etimer && busy))
        begin
            mem <= dq_out;
            wn <= wn + 1;
            wr_addr <= addr;
            tog_cnt <= busy_len;
            if (dq_out == 16'h0030)
                win_cnt <= WIN;
            if (dq_out == 16'h0010)
                etimer <= 1'b1;
        end
        if (ctl.oe_n && !prev.oe_n)
        begin
            rn <= rn + 1;
            rd_addr <= addr;
            if (busy)
            begin
                tog <= ~tog;
                tog2 <= tog2 ^ erasing;
                tog_cnt <= tog_cnt - 12'h001;
            end
        end
    end
endmodule

// ==== fwsr_host_test.sv ====
// self-checking bench for the flash status host controller
`timescale 1ns/1ns
module fwsr_host_test;
    localparam logic [2:0] R_CT = fwsr_pkg::REG_CTRL;
    localparam logic [2:0] R_AD = fwsr_pkg::REG_ADDR;
    localparam logic [2:0] R_WD = fwsr_pkg::REG_WDATA;
    localparam logic [2:0] R_ST = fwsr_pkg::REG_STATUS;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] sw_addr = 3'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    logic irq;
    logic [21:0] flash_addr;
    logic [15:0] flash_dq_out;
    logic [15:0] flash_dq_in;
    fwsr_pkg::fwsr_ctl_t flash_ctl;
    logic flash_ready_busy_n;
    logic [11:0] busy_len = 12'h000;
    logic abort_on = 1'b0;
    logic tlimit_on = 1'b0;
    logic [15:0] wr_cnt;
    logic [15:0] rd_cnt;
    logic [21:0] wr_addr;
    logic [21:0] rd_addr;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [31:0] rv;
    logic [31:0] msk = 32'h1f;
    logic [15:0] d;
    logic [21:0] a;
    logic [15:0] n_rd;
    logic [15:0] n_wr;

    always #5 sys_clk = ~sys_clk;

    // short erase gap keeps the fast-mode case quick
    fwsr_host #(.GAP_CYC(200)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in), .flash_ctl(flash_ctl),
        .flash_ready_busy_n(flash_ready_busy_n));
    fwsr_flash_model partner (.clk(sys_clk), .addr(flash_addr), .dq_out(flash_dq_out), .ctl(flash_ctl),
        .dq_in(flash_dq_in), .ready_busy_n(flash_ready_busy_n), .busy_len(busy_len), .abort_on(abort_on),
        .tlimit_on(tlimit_on), .wr_cnt(wr_cnt), .rd_cnt(rd_cnt), .wr_addr(wr_addr), .rd_addr(rd_addr));

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] ad, input logic [31:0] v);
        @(posedge sys_clk);
        sw_wr <= 1'b1;
        sw_addr <= ad;
        sw_wdata <= v;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] ad, output logic [31:0] v);
        @(posedge sys_clk);
        sw_rd <= 1'b1;
        sw_addr <= ad;
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask

    // expected interrupt level for a status word under a mask
    function automatic logic [31:0] exp_irq(input logic [31:0] st, input logic [31:0] m);
        return {31'h0, |(st & m)};
    endfunction

    // start an operation, wait for its event, check irq, clear the event
    task automatic run_op(input logic [2:0] op, input logic [31:0] fl, output logic [31:0] st);
        wr(R_CT, fl | 32'h8 | {29'h0, op});
        st = 32'h0;
        for (int i = 0; i < 2000 && st == 32'h0; i++)
            rd(R_ST, st);
        check({31'h0, irq}, exp_irq(st, msk), "irq level");
        wr(R_ST, st);
        @(posedge sys_clk);
        #1 check({31'h0, irq}, 32'h0, "irq after clear");
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        close_out();
    end

    initial
    begin
        rv = $urandom(32'hfe39);
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(R_ST, rv);
        check(rv, 32'h0, "status after reset");
        rd(3'h7, rv);
        check(rv, 32'h0, "unmapped index");
        wr(fwsr_pkg::REG_MASK, msk);
        // random program and read-back cycles
        for (int k = 0; k < 3; k++)
        begin
            a = 22'($urandom);
            d = 16'($urandom);
            wr(R_AD, {10'h0, a});
            wr(R_WD, {16'h0, d});
            run_op(fwsr_pkg::OP_WRITE, 32'h0, rv);
            check(rv, 32'h1, "write done");
            check({10'h0, wr_addr}, {10'h0, a}, "write address");
            run_op(fwsr_pkg::OP_READ, 32'h0, rv);
            rd(fwsr_pkg::REG_RDATA, rv);
            check(rv, {16'h0, d}, "read back");
        end
        // unused op codes end at once as refused
        run_op(3'h5 + 3'($urandom_range(2)), 32'h0, rv);
        check(rv, 32'h10, "undefined op refused");
        // program then poll at the last written address
        busy_len <= 12'd5;
        // abort, limit and toggle bits clear so the array word cannot pass for status
        d = 16'($urandom) & 16'hff9d;
        wr(R_WD, {16'h0, d});
        run_op(fwsr_pkg::OP_WRITE, 32'h0, rv);
        wr(R_AD, {10'h0, a ^ 22'h1});
        n_rd = rd_cnt;
        run_op(fwsr_pkg::OP_POLL, 32'h10, rv);
        check(rv, 32'h1, "poll done");
        check({10'h0, rd_addr}, {10'h0, a}, "poll address");
        check({31'h0, (rd_cnt - n_rd) >= 16'd6}, 32'h1, "polled until toggle stopped");
        // buffer abort, masked interrupt, lock and abort reset
        msk = 32'h1b;
        wr(fwsr_pkg::REG_MASK, msk);
        busy_len <= 12'd50;
        abort_on <= 1'b1;
        run_op(fwsr_pkg::OP_WRITE, 32'h0, rv);
        run_op(fwsr_pkg::OP_POLL, 32'h0, rv);
        check(rv, 32'h4, "abort event");
        rd(R_CT, rv);
        check({31'h0, rv[7]}, 32'h1, "abort lock");
        run_op(fwsr_pkg::OP_READ, 32'h0, rv);
        check(rv, 32'h10, "refused while locked");
        abort_on <= 1'b0;
        busy_len <= 12'd0;
        n_wr = wr_cnt;
        run_op(fwsr_pkg::OP_ABORT_RST, 32'h0, rv);
        check(rv, 32'h1, "abort reset done");
        check({16'h0, wr_cnt - n_wr}, 32'h3, "abort reset writes");
        rd(R_CT, rv);
        check({31'h0, rv[7]}, 32'h0, "lock cleared");
        check({31'h0, rv[8]}, 32'h1, "ready after abort reset");
        // timing limit with toggle still running
        tlimit_on <= 1'b1;
        busy_len <= 12'd60;
        run_op(fwsr_pkg::OP_WRITE, 32'h0, rv);
        run_op(fwsr_pkg::OP_POLL, 32'h0, rv);
        check(rv, 32'h2, "timing limit fail");
        tlimit_on <= 1'b0;
        // sector erase adds: fast, fast back to back, checked, late
        busy_len <= 12'd1000;
        wr(R_WD, 32'h30);
        run_op(fwsr_pkg::OP_ERASE_ADD, 32'h20, rv);
        check(rv, 32'h1, "first erase add");
        n_rd = rd_cnt;
        n_wr = wr_cnt;
        run_op(fwsr_pkg::OP_ERASE_ADD, 32'h20, rv);
        check(rv, 32'h1, "fast erase add");
        check({16'h0, rd_cnt}, {16'h0, n_rd}, "fast add skips reads");
        check({16'h0, wr_cnt}, {16'h0, n_wr + 16'h1}, "fast add writes");
        n_rd = rd_cnt;
        run_op(fwsr_pkg::OP_ERASE_ADD, 32'h0, rv);
        check(rv, 32'h1, "checked add in window");
        check({31'h0, (rd_cnt - n_rd) >= 16'd3}, 32'h1, "checks read status");
        repeat (450) @(posedge sys_clk);
        n_wr = wr_cnt;
        run_op(fwsr_pkg::OP_ERASE_ADD, 32'h0, rv);
        check(rv, 32'h8, "late add rejected");
        check({16'h0, wr_cnt}, {16'h0, n_wr}, "rejected add not written");
        rd(R_CT, rv);
        check({31'h0, rv[8]}, 32'h0, "busy seen while erasing");
        close_out();
    end
endmodule
